// ===== logic/trap_capture_defs.vh
// Constants for the exception state capture block.
// Assumes big-endian bit numbering of the processor: field bit n sits at vector bit 31-n.
`ifndef TRAP_CAPTURE_DEFS_VH
`define TRAP_CAPTURE_DEFS_VH

// ==========================================================
// Special register selectors
`define SEL_FAULT_ADDRESS   16'h0003
`define SEL_TRAP_STATUS     16'h0005
`define SEL_DELAY_BRANCH    16'h000b

// ==========================================================
// Reset values
`define RST_WORD            32'h00000000
`define RST_CAUSE           5'h00
`define RST_DETAIL          7'h00

// ==========================================================
// Cause codes
`define CAUSE_STREAM        5'h00
`define CAUSE_UNALIGNED     5'h01
`define CAUSE_ILLEGAL       5'h02
`define CAUSE_IBUS          5'h03
`define CAUSE_DBUS          5'h04
`define CAUSE_DIVIDE        5'h05
`define CAUSE_FPU           5'h06
`define CAUSE_PRIV          5'h07
`define CAUSE_DSTORAGE      5'h10
`define CAUSE_ISTORAGE      5'h11
`define CAUSE_DMISS         5'h12
`define CAUSE_IMISS         5'h13

// ==========================================================
// Detail field positions, counted within the 7-bit detail field (bit 20 is index 6)
`define DET_B20             6
`define DET_B21             5
`define DET_REG_HI          4
`define DET_LINK_HI         3
`endif

// ===== logic/exception_state_capture.v
// Exception state capture: faulting address, trap status and delay branch target registers.
// Assumes the pipeline reports a taken exception as a one-cycle strobe with its cause and details.
//
// Functional notes
// - Unaligned access loads full address
// - Peripheral data bus error captures access address
// - Storage and miss faults capture effective address
// - Other causes leave fault address undefined
// - Selector 0x0003 reads fault address
// - Selector 0x0005 reads trap status, read-only
// - Bit 19 flags delay slot origin
// - Cause codes zero to seven
// - Memory management cause codes sixteen to nineteen
// - Unaligned details: word, store, register index
// - Bus error bit 20 marks local memory error
// - Divide bit 20: zero or overflow
// - Stream details hold link index
// - Data storage: zone hit, store bit
// - Instruction storage: zone hit only
// - Data miss: store bit only
// - Branch target exists with exception support
// - Capture branch targets while handler inactive
// - Selector 0x000B reads branch target
// - Branch target 32 bits, read-only, resets zero
// - Handler active flag gates target capture
`timescale 1ns/1ps
`include "trap_capture_defs.vh"

module exception_state_capture #(
  parameter EXCEPTION_SUPPORT = 1
) (
  // Clock and reset
  input  wire        I_CLK,
  input  wire        I_NRST,
  // Exception report from pipeline
  input  wire        I_TRAP_TAKEN,
  input  wire [4:0]  I_TRAP_CAUSE_CODE,
  input  wire        I_TRAP_IN_DELAY_SLOT,
  input  wire [31:0] I_TRAP_ADDRESS,
  input  wire        I_ACCESS_IS_WORD,
  input  wire        I_ACCESS_IS_STORE,
  input  wire [4:0]  I_ACCESS_GPR_INDEX,
  input  wire        I_LOCAL_MEM_ECC_ERROR,
  input  wire        I_PERIPH_PORT_ERROR,
  input  wire        I_DIVIDE_FAULT_KIND,
  input  wire [3:0]  I_STREAM_LINK_INDEX,
  input  wire        I_ZONE_PROTECT_HIT,
  // Delay-slot branch report
  input  wire        I_DELAY_BRANCH_VALID,
  input  wire [31:0] I_DELAY_BRANCH_TARGET,
  input  wire        I_HANDLER_ACTIVE_FLAG,
  // Move-from-special read port
  input  wire        I_MOVE_FROM_SPECIAL_OP,
  input  wire [15:0] I_SPECIAL_REG_SELECTOR,
  output wire        O_SPECIAL_READ_HIT,
  output reg  [31:0] O_SPECIAL_READ_DATA
);

  // ==========================================================
  // Reset synchroniser
  reg rst_meta_ff;
  reg rst_sync_ff;
  always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire nrst = rst_sync_ff;

  // ==========================================================
  // Capture decode
  reg  [31:0] fault_address_ff;
  reg         delay_slot_flag_ff;
  reg  [4:0]  trap_cause_code_ff;
  reg  [6:0]  cause_detail_bits_ff;
  reg  [31:0] delay_branch_target_ff;
  reg  [6:0]  nxt_detail;
  reg         addr_load;

  always @* begin
    nxt_detail = `RST_DETAIL;
    addr_load  = 1'b0;
    case (I_TRAP_CAUSE_CODE)
      `CAUSE_UNALIGNED: begin
        addr_load = 1'b1;
        nxt_detail[`DET_B20] = I_ACCESS_IS_WORD;
        nxt_detail[`DET_B21] = I_ACCESS_IS_STORE;
        nxt_detail[`DET_REG_HI:0] = I_ACCESS_GPR_INDEX;
      end
      `CAUSE_IBUS: begin
        nxt_detail[`DET_B20] = I_LOCAL_MEM_ECC_ERROR;
      end
      `CAUSE_DBUS: begin
        nxt_detail[`DET_B20] = I_LOCAL_MEM_ECC_ERROR;
        addr_load = I_PERIPH_PORT_ERROR;
      end
      `CAUSE_DIVIDE: begin
        nxt_detail[`DET_B20] = I_DIVIDE_FAULT_KIND;
      end
      `CAUSE_STREAM: begin
        nxt_detail[`DET_LINK_HI:0] = I_STREAM_LINK_INDEX;
      end
      `CAUSE_DSTORAGE: begin
        addr_load = 1'b1;
        nxt_detail[`DET_B20] = I_ZONE_PROTECT_HIT;
        nxt_detail[`DET_B21] = I_ACCESS_IS_STORE;
      end
      `CAUSE_ISTORAGE: begin
        addr_load = 1'b1;
        nxt_detail[`DET_B20] = I_ZONE_PROTECT_HIT;
      end
      `CAUSE_DMISS: begin
        addr_load = 1'b1;
        nxt_detail[`DET_B21] = I_ACCESS_IS_STORE;
      end
      `CAUSE_IMISS: begin
        addr_load = 1'b1;
      end
      // Other causes keep the detail field zero and the old address, which software must ignore.
      default: begin
        nxt_detail = `RST_DETAIL;
      end
    endcase
  end

  // ==========================================================
  // Status and address registers
  always @(posedge I_CLK or negedge nrst) begin
    if (!nrst) begin
      fault_address_ff     <= `RST_WORD;
      delay_slot_flag_ff   <= 1'b0;
      trap_cause_code_ff   <= `RST_CAUSE;
      cause_detail_bits_ff <= `RST_DETAIL;
    end else if (I_TRAP_TAKEN) begin
      delay_slot_flag_ff   <= I_TRAP_IN_DELAY_SLOT;
      trap_cause_code_ff   <= I_TRAP_CAUSE_CODE;
      cause_detail_bits_ff <= nxt_detail;
      if (addr_load) begin
        fault_address_ff <= I_TRAP_ADDRESS;
      end
    end
  end

  // ==========================================================
  // Delay branch target register
  // Capture stops while the handler runs so a branch inside the handler cannot overwrite the resume point.
  generate
    if (EXCEPTION_SUPPORT != 0) begin : g_btr
      always @(posedge I_CLK or negedge nrst) begin
        if (!nrst) begin
          delay_branch_target_ff <= `RST_WORD;
        end else if (I_DELAY_BRANCH_VALID && !I_HANDLER_ACTIVE_FLAG) begin
          delay_branch_target_ff <= I_DELAY_BRANCH_TARGET;
        end
      end
    end else begin : g_no_btr
      // A clocked constant, so the register holds a defined zero from reset without a register of its own.
      always @(posedge I_CLK or negedge nrst) begin
        if (!nrst) begin
          delay_branch_target_ff <= `RST_WORD;
        end else begin
          delay_branch_target_ff <= `RST_WORD;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Move-from-special read path
  wire sel_fa = (I_SPECIAL_REG_SELECTOR == `SEL_FAULT_ADDRESS);
  wire sel_ts = (I_SPECIAL_REG_SELECTOR == `SEL_TRAP_STATUS);
  wire sel_bt = (I_SPECIAL_REG_SELECTOR == `SEL_DELAY_BRANCH) && (EXCEPTION_SUPPORT != 0);
  assign O_SPECIAL_READ_HIT = I_MOVE_FROM_SPECIAL_OP && (sel_fa || sel_ts || sel_bt);

  always @(posedge I_CLK or negedge nrst) begin
    if (!nrst) begin
      O_SPECIAL_READ_DATA <= `RST_WORD;
    end else if (I_MOVE_FROM_SPECIAL_OP) begin
      if (sel_fa) begin
        O_SPECIAL_READ_DATA <= fault_address_ff;
      end else if (sel_ts) begin
        // Vector bits 12..0 hold big-endian bits 19..31; upper bits are reserved zero.
        O_SPECIAL_READ_DATA <= {19'h00000, delay_slot_flag_ff, cause_detail_bits_ff,
                                trap_cause_code_ff};
      end else if (sel_bt) begin
        O_SPECIAL_READ_DATA <= delay_branch_target_ff;
      end else begin
        O_SPECIAL_READ_DATA <= `RST_WORD;
      end
    end
  end

endmodule

// ===== bench/trap_capture_asserts.sv
// Port checker for the exception state capture block.
// Assumes a read answers on the edge after its request.
`timescale 1ns/1ps
module trap_capture_asserts #(parameter EXCEPTION_SUPPORT = 1) (
  input wire I_CLK,
  input wire I_NRST,
  input wire I_TRAP_TAKEN,
  input wire [4:0] I_TRAP_CAUSE_CODE,
  input wire I_TRAP_IN_DELAY_SLOT,
  input wire [31:0] I_TRAP_ADDRESS,
  input wire I_PERIPH_PORT_ERROR,
  input wire I_DELAY_BRANCH_VALID,
  input wire [31:0] I_DELAY_BRANCH_TARGET,
  input wire I_HANDLER_ACTIVE_FLAG,
  input wire I_MOVE_FROM_SPECIAL_OP,
  input wire [15:0] I_SPECIAL_REG_SELECTOR,
  input wire O_SPECIAL_READ_HIT,
  input wire [31:0] O_SPECIAL_READ_DATA
);
  // ====================
  // Properties
  wire op = I_MOVE_FROM_SPECIAL_OP;
  wire [31:0] rd = O_SPECIAL_READ_DATA;
  wire [4:0] cc = I_TRAP_CAUSE_CODE;
  wire rea = op && I_SPECIAL_REG_SELECTOR == 16'h0003;
  wire rsr = op && I_SPECIAL_REG_SELECTOR == 16'h0005;
  wire rbt = op && I_SPECIAL_REG_SELECTOR == 16'h000b;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);
  hit_map_a: assert property (O_SPECIAL_READ_HIT == (rea || rsr || rbt && EXCEPTION_SUPPORT != 0))
    else $error("read hit decode wrong");
  unmapped_zero_a: assert property (op && !O_SPECIAL_READ_HIT |=> rd == 32'h0)
    else $error("unmapped read not zero");
  unalign_addr_a: assert property (I_TRAP_TAKEN && cc == 5'h01 ##1 rea |=> rd == $past(I_TRAP_ADDRESS, 2))
    else $error("unaligned address lost");
  periph_addr_a: assert property (I_TRAP_TAKEN && cc == 5'h04 && I_PERIPH_PORT_ERROR ##1 rea
    |=> rd == $past(I_TRAP_ADDRESS, 2)) else $error("data bus address lost");
  mmu_addr_a: assert property (I_TRAP_TAKEN && cc[4] ##1 rea |=> rd == $past(I_TRAP_ADDRESS, 2))
    else $error("effective address lost");
  status_word_a: assert property (I_TRAP_TAKEN ##1 rsr
    |=> rd[12] == $past(I_TRAP_IN_DELAY_SLOT, 2) && rd[4:0] == $past(cc, 2)) else $error("status wrong");
  reserved_zero_a: assert property (rsr |=> rd[31:13] == 19'h0)
    else $error("reserved status bits set");
  branch_capture_a: assert property (I_DELAY_BRANCH_VALID && !I_HANDLER_ACTIVE_FLAG ##1 rbt
    |=> rd == $past(I_DELAY_BRANCH_TARGET, 2)) else $error("branch target lost");
  read_hold_a: assert property (!op |=> $stable(rd))
    else $error("read data moved");
  cover property (I_TRAP_TAKEN && I_TRAP_IN_DELAY_SLOT ##1 rsr);
  cover property (I_TRAP_TAKEN && cc[4] ##1 rea);
  cover property (op && !O_SPECIAL_READ_HIT);
endmodule
bind exception_state_capture trap_capture_asserts #(.EXCEPTION_SUPPORT(EXCEPTION_SUPPORT)) chk (.*);

// ===== bench/trap_handler_model.sv
// Handler software stand-in issuing special register reads.
// Assumes i_run stays low until requests are allowed.
`timescale 1ns/1ps
module trap_handler_model (
  // ====================
  // Clock and enable
  input  wire        i_clk,
  input  wire        i_run,
  // Read request
  output reg         o_op,
  output reg  [15:0] o_sel
);
  reg [15:0] pick;
  initial {o_op, o_sel} = 17'h00000;
  // Mostly mapped selectors; the odd one tests refusal.
  always @(posedge i_clk) begin
    pick = $urandom;
    case (pick[1:0])
      2'h0: pick = 16'h0003;
      2'h1: pick = 16'h0005;
      2'h2: pick = 16'h000b;
      default: pick = {pick[15:2], 2'h0};
    endcase
    #1;
    o_op <= i_run && $urandom % 2;
    o_sel <= pick;
  end
endmodule

// ===== bench/exception_state_capture_tb_top.sv
// Self-checking bench for the exception state capture block.
// Assumes the handler model makes the reads while this bench raises traps.
`timescale 1ns/1ps
module exception_state_capture_tb_top;
  reg I_CLK, I_NRST, tk, ds, w, st, ecc, pe, dk, z, bv, ha, run;
  reg [4:0] c, gpr;
  reg [3:0] lnk;
  reg [31:0] addr, bt, fault_address, trap_status, delay_branch_target;
  reg [31:0] exp_rd = 32'h0;
  integer bad_count = 0, compares = 0, cyc = 0;
  wire op, hit;
  wire [15:0] sel;
  wire [31:0] rd;
  trap_handler_model hm (.i_clk(I_CLK), .i_run(run), .o_op(op), .o_sel(sel));
  exception_state_capture uut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_TRAP_TAKEN(tk),
    .I_TRAP_CAUSE_CODE(c), .I_TRAP_IN_DELAY_SLOT(ds), .I_TRAP_ADDRESS(addr),
    .I_ACCESS_IS_WORD(w), .I_ACCESS_IS_STORE(st), .I_ACCESS_GPR_INDEX(gpr),
    .I_LOCAL_MEM_ECC_ERROR(ecc), .I_PERIPH_PORT_ERROR(pe), .I_DIVIDE_FAULT_KIND(dk),
    .I_STREAM_LINK_INDEX(lnk), .I_ZONE_PROTECT_HIT(z), .I_DELAY_BRANCH_VALID(bv),
    .I_DELAY_BRANCH_TARGET(bt), .I_HANDLER_ACTIVE_FLAG(ha), .I_MOVE_FROM_SPECIAL_OP(op),
    .I_SPECIAL_REG_SELECTOR(sel), .O_SPECIAL_READ_HIT(hit), .O_SPECIAL_READ_DATA(rd));
  // ====================
  // Reference model
  function [6:0] det(input [4:0] k);
    case (k)
      5'h00: det = {3'h0, lnk};
      5'h01: det = {w, st, gpr};
      5'h03, 5'h04: det = {ecc, 6'h00};
      5'h05: det = {dk, 6'h00};
      5'h10: det = {z, st, 5'h00};
      5'h11: det = {z, 6'h00};
      5'h12: det = {1'b0, st, 5'h00};
      default: det = 7'h00;
    endcase
  endfunction
  task check(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (e !== g) begin
        bad_count = bad_count + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // The model reads the old registers first, since a read beside a trap sees old state.
  always @(posedge I_CLK) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      bad_count = bad_count + 1;
      test_done;
    end
    if (!I_NRST)
      {fault_address, trap_status, delay_branch_target, exp_rd} = 128'h0;
    else begin
      if (op)
        exp_rd = sel == 16'h0003 ? fault_address : sel == 16'h0005 ? trap_status : sel == 16'h000b ? delay_branch_target : 32'h0;
      if (tk) begin
        trap_status = {19'h0, ds, det(c), c};
        if (c == 5'h01 || c[4] || c == 5'h04 && pe)
          fault_address = addr;
      end
      if (bv && !ha)
        delay_branch_target = bt;
    end
  end
  always @(negedge I_CLK) begin
    check("data", exp_rd, rd);
    check("hit", {31'h0, op && (sel == 16'h0003 || sel == 16'h0005 || sel == 16'h000b)}, {31'h0, hit});
  end
  initial begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end
  initial begin
    {I_NRST, run, tk, ds, w, st, ecc, pe, dk, z, bv, ha, c, gpr, lnk, addr, bt} = 0;
    void'($urandom(32'h28c9));
    repeat (5) @(posedge I_CLK);
    #1 I_NRST = 1'b1;
    repeat (2) @(posedge I_CLK);
    #1 run = 1'b1;
    repeat (3000) begin
      @(posedge I_CLK);
      #1;
      {tk, ds, w, st, ecc, pe, dk, z, bv, ha, gpr, lnk} = $urandom;
      {addr, bt} = {$urandom, $urandom};
      c = $urandom % 12;
      if (c > 5'h07)
        c = c + 5'h08;
    end
    test_done;
  end
endmodule
